// ==== inc/dgcfg_pkg.sv ====
// Constants for the global control and status register bank
// Operation
// - Eight-bit page selector, reset zero, read/write
// - Writing reset bit restores all register defaults
// - Reset bit clears itself after the reset
// - Bits five-four pick reference quick-charge time
// - Bit three: sleep exit powers regulator, reference
// - Bit two picks analog supply scheme
// - Bit one picks io supply scheme
// - Bit zero zero keeps device asleep
// - Analog supply flag forces analog scheme zero
// - Io supply flag forces io scheme zero
// - Status bit one reports undervoltage shutdown
// - Status bit zero picks wake after undervoltage
// - Misc bit six disables clock-error action
// - Misc bit one enables group address answer
package dgcfg_pkg;
    // Register offsets
    localparam logic [7:0] OFS_PAGE_SELECT = 8'h00;
    localparam logic [7:0] OFS_SOFT_RESET_CTRL = 8'h01;
    localparam logic [7:0] OFS_DEVICE_POWER_CONFIG = 8'h02;
    localparam logic [7:0] OFS_SUPPLY_BROWNOUT_STATUS = 8'h03;
    localparam logic [7:0] OFS_MISC_CONTROL = 8'h04;
    // Reset values
    localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
    localparam logic [7:0] RST_DEVICE_POWER_CONFIG = 8'h00;
    localparam logic [7:0] RST_SUPPLY_BROWNOUT_STATUS = 8'h00;
    localparam logic [7:0] RST_MISC_CONTROL = 8'h00;
    // Writable masks
    localparam logic [7:0] WMASK_DEVICE_POWER_CONFIG = 8'h3f;
    localparam logic [7:0] WMASK_SUPPLY_BROWNOUT_STATUS = 8'h01;
    localparam logic [7:0] WMASK_MISC_CONTROL = 8'h42;
    // Field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_QCHG_LO = 4;
    localparam int BIT_SLEEP_EXIT_REF = 3;
    localparam int BIT_ANALOG_SCHEME = 2;
    localparam int BIT_IO_SCHEME = 1;
    localparam int BIT_AWAKE = 0;
    localparam int BIT_ANALOG_FORCED = 7;
    localparam int BIT_IO_FORCED = 6;
    localparam int BIT_UV_SHUTDOWN = 1;
    localparam int BIT_UV_WAKE = 0;
    localparam int BIT_IGNORE_CLK_ERR = 6;
    localparam int BIT_GROUP_ADDR = 1;
    // Quick-charge durations in microseconds, per code
    localparam int QCHG_US_0 = 3500;
    localparam int QCHG_US_1 = 10000;
    localparam int QCHG_US_2 = 50000;
    localparam int QCHG_US_3 = 100000;
    localparam int CLK_MHZ = 200;
endpackage

// ==== hdl/dgcfg_qchg_sel.sv ====
// Quick-charge duration lookup in clock cycles
`timescale 1ns/10ps
module dgcfg_qchg_sel
(
    // Code in
    input wire logic [1:0] code,
    // Cycle count out
    output logic [31:0] cycles
);
    // Map code to cycle count at the core clock rate
    always_comb
    begin
        case (code)
            2'h0: cycles = 32'(dgcfg_pkg::QCHG_US_0 * dgcfg_pkg::CLK_MHZ);
            2'h1: cycles = 32'(dgcfg_pkg::QCHG_US_1 * dgcfg_pkg::CLK_MHZ);
            2'h2: cycles = 32'(dgcfg_pkg::QCHG_US_2 * dgcfg_pkg::CLK_MHZ);
            default: cycles = 32'(dgcfg_pkg::QCHG_US_3 * dgcfg_pkg::CLK_MHZ);
        endcase
    end
endmodule

// ==== hdl/dgcfg_regs.sv ====
// Global control and status register bank
`timescale 1ns/10ps
module dgcfg_regs
(
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    // Register access from the control bus decoder
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic RVALID,
    // Supply and fault detectors
    input wire logic ANALOG_3V3_DET,
    input wire logic IO_3V3_DET,
    input wire logic UV_SHUTDOWN_EVT,
    input wire logic CLK_ERR_DET,
    // Bus address strap pins
    input wire logic [1:0] ADDR_PINS,
    // Controls out
    output logic [7:0] PAGE,
    output logic [1:0] REF_QUICK_CHARGE_TIME,
    output logic SLEEP_EXIT_REF_EN,
    output logic ANALOG_SUPPLY_SCHEME,
    output logic IO_SUPPLY_SCHEME,
    output logic AWAKE,
    output logic CLK_ERR_ACTION,
    output logic GROUP_ADDRESS_ENABLE,
    output logic [1:0] EFF_ADDR_PINS,
    output logic QCHG_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] page_reg, page_next;
    logic [7:0] pwr_reg, pwr_next;
    logic ana_flag_reg, ana_flag_next;
    logic io_flag_reg, io_flag_next;
    logic uv_flag_reg, uv_flag_next;
    logic uv_wake_reg, uv_wake_next;
    logic [7:0] misc_reg, misc_next;
    logic sreset_reg, sreset_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic awake_q_reg, awake_q_next;
    logic [31:0] qcnt_reg, qcnt_next;
    logic [31:0] qchg_cycles;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    dgcfg_qchg_sel u_qchg
    (
        .code(pwr_reg[5:4]),
        .cycles(qchg_cycles)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state for the register bank
    always_comb
    begin
        page_next = page_reg;
        pwr_next = pwr_reg;
        uv_wake_next = uv_wake_reg;
        misc_next = misc_reg;
        sreset_next = 1'b0;
        ana_flag_next = ANALOG_3V3_DET;
        io_flag_next = IO_3V3_DET;
        uv_flag_next = uv_flag_reg | UV_SHUTDOWN_EVT;
        if (sreset_reg)
        begin
            // Previous cycle's soft reset: restore defaults
            page_next = dgcfg_pkg::RST_PAGE_SELECT;
            pwr_next = dgcfg_pkg::RST_DEVICE_POWER_CONFIG;
            uv_wake_next = dgcfg_pkg::RST_SUPPLY_BROWNOUT_STATUS[0];
            misc_next = dgcfg_pkg::RST_MISC_CONTROL;
            uv_flag_next = UV_SHUTDOWN_EVT;
        end
        else if (WR_EN)
        begin
            if (hit(ADDR, dgcfg_pkg::OFS_PAGE_SELECT))
                page_next = WDATA;
            if (hit(ADDR, dgcfg_pkg::OFS_SOFT_RESET_CTRL))
                sreset_next = WDATA[dgcfg_pkg::BIT_SOFT_RESET];
            if (hit(ADDR, dgcfg_pkg::OFS_DEVICE_POWER_CONFIG))
                pwr_next = WDATA & dgcfg_pkg::WMASK_DEVICE_POWER_CONFIG;
            if (hit(ADDR, dgcfg_pkg::OFS_SUPPLY_BROWNOUT_STATUS))
                uv_wake_next = WDATA[dgcfg_pkg::BIT_UV_WAKE];
            if (hit(ADDR, dgcfg_pkg::OFS_MISC_CONTROL))
                misc_next = WDATA & dgcfg_pkg::WMASK_MISC_CONTROL;
        end
        // Undervoltage shutdown: wake select decides sleep state
        if (UV_SHUTDOWN_EVT)
            pwr_next[dgcfg_pkg::BIT_AWAKE] = uv_wake_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data path
    always_comb
    begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (RD_EN)
        begin
            rvalid_next = 1'b1;
            case (ADDR)
                dgcfg_pkg::OFS_PAGE_SELECT: rdata_next = page_reg;
                dgcfg_pkg::OFS_SOFT_RESET_CTRL: rdata_next = {7'h00, sreset_reg};
                dgcfg_pkg::OFS_DEVICE_POWER_CONFIG: rdata_next = pwr_reg;
                dgcfg_pkg::OFS_SUPPLY_BROWNOUT_STATUS:
                    rdata_next = {ana_flag_reg, io_flag_reg, 4'h0, uv_flag_reg, uv_wake_reg};
                dgcfg_pkg::OFS_MISC_CONTROL: rdata_next = misc_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Quick-charge timer on wake with reference enabled
    always_comb
    begin
        awake_q_next = pwr_reg[dgcfg_pkg::BIT_AWAKE];
        qcnt_next = qcnt_reg;
        if (pwr_reg[dgcfg_pkg::BIT_AWAKE] && !awake_q_reg
            && pwr_reg[dgcfg_pkg::BIT_SLEEP_EXIT_REF])
            qcnt_next = qchg_cycles;
        else if (!pwr_reg[dgcfg_pkg::BIT_AWAKE])
            qcnt_next = 32'h0000_0000;
        else if (qcnt_reg != 32'h0000_0000)
            qcnt_next = qcnt_reg - 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            page_reg <= dgcfg_pkg::RST_PAGE_SELECT;
            pwr_reg <= dgcfg_pkg::RST_DEVICE_POWER_CONFIG;
            ana_flag_reg <= 1'b0;
            io_flag_reg <= 1'b0;
            uv_flag_reg <= 1'b0;
            uv_wake_reg <= 1'b0;
            misc_reg <= dgcfg_pkg::RST_MISC_CONTROL;
            sreset_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            awake_q_reg <= 1'b0;
            qcnt_reg <= 32'h0000_0000;
        end
        else if (CE)
        begin
            page_reg <= page_next;
            pwr_reg <= pwr_next;
            ana_flag_reg <= ana_flag_next;
            io_flag_reg <= io_flag_next;
            uv_flag_reg <= uv_flag_next;
            uv_wake_reg <= uv_wake_next;
            misc_reg <= misc_next;
            sreset_reg <= sreset_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            awake_q_reg <= awake_q_next;
            qcnt_reg <= qcnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered control outputs
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            PAGE <= 8'h00;
            REF_QUICK_CHARGE_TIME <= 2'h0;
            SLEEP_EXIT_REF_EN <= 1'b0;
            ANALOG_SUPPLY_SCHEME <= 1'b0;
            IO_SUPPLY_SCHEME <= 1'b0;
            AWAKE <= 1'b0;
            CLK_ERR_ACTION <= 1'b0;
            GROUP_ADDRESS_ENABLE <= 1'b0;
            EFF_ADDR_PINS <= 2'h0;
            QCHG_ACTIVE <= 1'b0;
        end
        else if (CE)
        begin
            PAGE <= page_next;
            REF_QUICK_CHARGE_TIME <= pwr_next[5:4];
            SLEEP_EXIT_REF_EN <= pwr_next[dgcfg_pkg::BIT_SLEEP_EXIT_REF];
            ANALOG_SUPPLY_SCHEME <= pwr_next[dgcfg_pkg::BIT_ANALOG_SCHEME]
                & ~ANALOG_3V3_DET;
            IO_SUPPLY_SCHEME <= pwr_next[dgcfg_pkg::BIT_IO_SCHEME]
                & ~IO_3V3_DET;
            AWAKE <= pwr_next[dgcfg_pkg::BIT_AWAKE];
            CLK_ERR_ACTION <= CLK_ERR_DET & ~misc_next[dgcfg_pkg::BIT_IGNORE_CLK_ERR];
            GROUP_ADDRESS_ENABLE <= misc_next[dgcfg_pkg::BIT_GROUP_ADDR];
            EFF_ADDR_PINS <= misc_next[dgcfg_pkg::BIT_GROUP_ADDR] ? 2'h0 : ADDR_PINS;
            QCHG_ACTIVE <= (qcnt_next != 32'h0000_0000);
        end
    end

    assign RDATA = rdata_reg;
    assign RVALID = rvalid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_page_write;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && WR_EN && !sreset_reg && ADDR == dgcfg_pkg::OFS_PAGE_SELECT)
            |=> (PAGE == $past(WDATA));
    endproperty
    a_page_write: assert property (p_page_write) else $error("page not written");

    property p_sreset_defaults;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && sreset_reg) |=> (PAGE == 8'h00 && GROUP_ADDRESS_ENABLE == 1'b0);
    endproperty
    a_sreset_defaults: assert property (p_sreset_defaults) else $error("defaults lost");

    property p_sreset_clear;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && sreset_reg) |=> !sreset_reg;
    endproperty
    a_sreset_clear: assert property (p_sreset_clear) else $error("reset bit stuck");

    property p_analog_forced;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && ANALOG_3V3_DET) |=> !ANALOG_SUPPLY_SCHEME;
    endproperty
    a_analog_forced: assert property (p_analog_forced) else $error("analog not forced");

    property p_io_forced;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && IO_3V3_DET) |=> !IO_SUPPLY_SCHEME;
    endproperty
    a_io_forced: assert property (p_io_forced) else $error("io not forced");

    property p_uv_sticky;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && UV_SHUTDOWN_EVT) |=> uv_flag_reg;
    endproperty
    a_uv_sticky: assert property (p_uv_sticky) else $error("undervoltage flag missed");

    property p_uv_wake;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && UV_SHUTDOWN_EVT && !WR_EN && !sreset_reg) |=> (AWAKE == $past(uv_wake_reg));
    endproperty
    a_uv_wake: assert property (p_uv_wake) else $error("wake select ignored");

    property p_clk_err;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && misc_reg[dgcfg_pkg::BIT_IGNORE_CLK_ERR] && !WR_EN && !sreset_reg)
            |=> !CLK_ERR_ACTION;
    endproperty
    a_clk_err: assert property (p_clk_err) else $error("clock error not ignored");

    property p_group_addr;
        @(posedge MCLK) disable iff (!RST_N)
        GROUP_ADDRESS_ENABLE |-> (EFF_ADDR_PINS == 2'h0);
    endproperty
    a_group_addr: assert property (p_group_addr) else $error("address bits not zero");

    property p_reserved_zero;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && RD_EN && ADDR == dgcfg_pkg::OFS_MISC_CONTROL) |=> (RDATA[7] == 1'b0 && RDATA[0] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_qchg_code;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && WR_EN && !sreset_reg && ADDR == dgcfg_pkg::OFS_DEVICE_POWER_CONFIG)
            |=> (REF_QUICK_CHARGE_TIME == $past(WDATA[5:4]));
    endproperty
    a_qchg_code: assert property (p_qchg_code) else $error("charge code lost");

    property p_exit_ref;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && WR_EN && !sreset_reg && ADDR == dgcfg_pkg::OFS_DEVICE_POWER_CONFIG)
            |=> (SLEEP_EXIT_REF_EN == $past(WDATA[dgcfg_pkg::BIT_SLEEP_EXIT_REF]));
    endproperty
    a_exit_ref: assert property (p_exit_ref) else $error("exit select lost");

    // Waking with the reference selected must start the charge timer
    property p_qchg_start;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && pwr_reg[dgcfg_pkg::BIT_AWAKE] && !awake_q_reg
            && pwr_reg[dgcfg_pkg::BIT_SLEEP_EXIT_REF]) |=> QCHG_ACTIVE;
    endproperty
    a_qchg_start: assert property (p_qchg_start) else $error("charge timer idle");

    property p_ana_scheme;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && WR_EN && !sreset_reg && !ANALOG_3V3_DET
            && ADDR == dgcfg_pkg::OFS_DEVICE_POWER_CONFIG)
            |=> (ANALOG_SUPPLY_SCHEME == $past(WDATA[dgcfg_pkg::BIT_ANALOG_SCHEME]));
    endproperty
    a_ana_scheme: assert property (p_ana_scheme) else $error("analog scheme lost");

    property p_io_scheme;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && WR_EN && !sreset_reg && !IO_3V3_DET
            && ADDR == dgcfg_pkg::OFS_DEVICE_POWER_CONFIG)
            |=> (IO_SUPPLY_SCHEME == $past(WDATA[dgcfg_pkg::BIT_IO_SCHEME]));
    endproperty
    a_io_scheme: assert property (p_io_scheme) else $error("io scheme lost");

    // Undervoltage events override the sleep bit, so they are left out
    property p_awake_write;
        @(posedge MCLK) disable iff (!RST_N)
        (CE && WR_EN && !sreset_reg && !UV_SHUTDOWN_EVT
            && ADDR == dgcfg_pkg::OFS_DEVICE_POWER_CONFIG)
            |=> (AWAKE == $past(WDATA[dgcfg_pkg::BIT_AWAKE]));
    endproperty
    a_awake_write: assert property (p_awake_write) else $error("sleep bit lost");
endmodule

// ==== tb/dgcfg_regs_test.sv ====
// Self-checking testbench for the global control and status register bank
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
    begin \
        n_compared++; \
        if ((gt) !== (ex)) \
        begin \
            mismatches++; \
            $display("ERROR %s expected %h seen %h", nm, ex, gt); \
        end \
    end
module dgcfg_regs_test;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} dgcfg_row_t;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic CE = 1'b1;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic RVALID;
    logic ANALOG_3V3_DET = 1'b0;
    logic IO_3V3_DET = 1'b0;
    logic UV_SHUTDOWN_EVT = 1'b0;
    logic CLK_ERR_DET = 1'b0;
    logic [1:0] ADDR_PINS = 2'h3;
    logic [7:0] PAGE;
    logic [1:0] REF_QUICK_CHARGE_TIME;
    logic SLEEP_EXIT_REF_EN, ANALOG_SUPPLY_SCHEME, IO_SUPPLY_SCHEME, AWAKE;
    logic CLK_ERR_ACTION, GROUP_ADDRESS_ENABLE, QCHG_ACTIVE;
    logic [1:0] EFF_ADDR_PINS;
    logic [7:0] got;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    // Reserved positions of mapped registers are only written as zero; unmapped offset 05 gets all ones; read-only bits may be ones
    dgcfg_row_t rows [7] = '{'{8'h00, 8'ha5, 8'ha5}, '{8'h00, 8'hff, 8'hff},
        '{8'h02, 8'h3f, 8'h3f}, '{8'h04, 8'h42, 8'h42}, '{8'h03, 8'hc3, 8'h01},
        '{8'h05, 8'hff, 8'h00}, '{8'h01, 8'h00, 8'h00}};

    dgcfg_regs dut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID),
        .ANALOG_3V3_DET(ANALOG_3V3_DET), .IO_3V3_DET(IO_3V3_DET),
        .UV_SHUTDOWN_EVT(UV_SHUTDOWN_EVT), .CLK_ERR_DET(CLK_ERR_DET), .ADDR_PINS(ADDR_PINS),
        .PAGE(PAGE), .REF_QUICK_CHARGE_TIME(REF_QUICK_CHARGE_TIME),
        .SLEEP_EXIT_REF_EN(SLEEP_EXIT_REF_EN), .ANALOG_SUPPLY_SCHEME(ANALOG_SUPPLY_SCHEME),
        .IO_SUPPLY_SCHEME(IO_SUPPLY_SCHEME), .AWAKE(AWAKE), .CLK_ERR_ACTION(CLK_ERR_ACTION),
        .GROUP_ADDRESS_ENABLE(GROUP_ADDRESS_ENABLE), .EFF_ADDR_PINS(EFF_ADDR_PINS),
        .QCHG_ACTIVE(QCHG_ACTIVE));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 5 ns period
    initial
    begin
        forever #2.5 MCLK = ~MCLK;
    end

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge MCLK)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle write strobe, held up to the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR_EN <= 1'b0;
    endtask

    // Read strobe; data and valid are looked at in the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, RVALID)
        d = RDATA;
    endtask

    // Let registered outputs settle
    task automatic idle(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    // Report and end the run
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (12) @(posedge MCLK);
        RST_N <= 1'b1;
        // Reset values of every register
        for (int i = 0; i < 5; i++)
        begin
            rd(i[7:0], got);
            `CHK("reset value", 8'h00, got)
        end
        // Row table: write then read back, read-only and unmapped bits masked
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, got);
            `CHK("readback", rows[i].exp, got)
        end
        // Field outputs; group enable and clock-error ignore are set
        CLK_ERR_DET <= 1'b1;
        wr(8'h02, 8'h2f);
        idle(3);
        `CHK("qchg active", 1'b1, QCHG_ACTIVE)
        `CHK("page", 8'hff, PAGE)
        `CHK("qchg", 2'h2, REF_QUICK_CHARGE_TIME)
        `CHK("exit ref", 1'b1, SLEEP_EXIT_REF_EN)
        `CHK("analog scheme", 1'b1, ANALOG_SUPPLY_SCHEME)
        `CHK("io scheme", 1'b1, IO_SUPPLY_SCHEME)
        `CHK("awake", 1'b1, AWAKE)
        `CHK("clk err gated", 1'b0, CLK_ERR_ACTION)
        `CHK("group en", 1'b1, GROUP_ADDRESS_ENABLE)
        `CHK("eff addr group", 2'h0, EFF_ADDR_PINS)
        wr(8'h04, 8'h00);
        idle(3);
        `CHK("clk err live", 1'b1, CLK_ERR_ACTION)
        `CHK("eff addr pins", 2'h3, EFF_ADDR_PINS)
        // Supply detectors override programmed schemes
        wr(8'h02, 8'h06);
        ANALOG_3V3_DET <= 1'b1;
        IO_3V3_DET <= 1'b1;
        idle(3);
        `CHK("analog forced", 1'b0, ANALOG_SUPPLY_SCHEME)
        `CHK("io forced", 1'b0, IO_SUPPLY_SCHEME)
        `CHK("asleep", 1'b0, AWAKE)
        `CHK("qchg idle", 1'b0, QCHG_ACTIVE)
        rd(8'h03, got);
        `CHK("supply status", 8'hc1, got)
        ANALOG_3V3_DET <= 1'b0;
        IO_3V3_DET <= 1'b0;
        // Undervoltage event with wake select set
        @(posedge MCLK);
        UV_SHUTDOWN_EVT <= 1'b1;
        @(posedge MCLK);
        UV_SHUTDOWN_EVT <= 1'b0;
        idle(3);
        `CHK("uv wake", 1'b1, AWAKE)
        rd(8'h03, got);
        `CHK("uv flag", 8'h03, got)
        // Clock enable low freezes state
        CE <= 1'b0;
        wr(8'h00, 8'h11);
        CE <= 1'b1;
        rd(8'h00, got);
        `CHK("frozen page", 8'hff, got)
        // Soft reset restores defaults and clears itself
        wr(8'h01, 8'h01);
        idle(3);
        `CHK("page after sreset", 8'h00, PAGE)
        for (int i = 0; i < 5; i++)
        begin
            rd(i[7:0], got);
            `CHK("after sreset", 8'h00, got)
        end
        // Mid-run reset returns the page to zero
        wr(8'h00, 8'h5a);
        @(posedge MCLK);
        RST_N <= 1'b0;
        @(posedge MCLK);
        RST_N <= 1'b1;
        idle(1);
        `CHK("page after reset", 8'h00, PAGE)
        close_out();
    end
endmodule
